// ===== include/lcmlr_pkg.sv
package lcmlr_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_MODE = 8'h01;
    localparam logic [7:0] OFS_LVL1 = 8'h02;
    localparam logic [7:0] OFS_LVL2 = 8'h03;
    localparam logic [7:0] OFS_LVL3 = 8'h04;
    localparam logic [7:0] OFS_LVL4 = 8'h05;
    localparam logic [7:0] RST_MODE = 8'h03;
    localparam logic [7:0] RST_LVL1 = 8'h40;
    localparam logic [7:0] RST_LVLX = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    // ----------------------------------------
    // mode field positions and codes
    // ----------------------------------------
    localparam int CH1_MODE_LSB = 0;
    localparam int CH2_MODE_LSB = 2;
    localparam int CH3_MODE_LSB = 4;
    localparam int CH4_MODE_LSB = 6;
    localparam int NUM_CH = 4;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_ON = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_PAT = 2'h3;
    // ----------------------------------------
    // current scale, in microamps
    // ----------------------------------------
    localparam int STEP_UA = 100;
    localparam int FULL_SCALE_UA = 25500;
    localparam int BIT7_UA = 12800;
endpackage : lcmlr_pkg

// ===== logic/lcmlr_gate.sv
`timescale 1ns/10ps
// ----------------------------------------
// per channel mode gate
// ----------------------------------------
module lcmlr_gate
    import lcmlr_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [1:0] i_mode,
    input wire logic [7:0] i_level,
    input wire logic i_pwm_s,
    input wire logic i_pat_s,
    output logic [7:0] o_level
);
    import lcmlr_pkg::*;

    logic pass;

    always_comb begin
        case (i_mode)
            MODE_OFF: pass = 1'b0;
            MODE_ON: pass = 1'b1;
            MODE_PWM: pass = i_pwm_s;
            MODE_PAT: pass = i_pat_s;
            default: pass = 1'b0;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_level <= 8'h00;
        end else begin
            o_level <= pass ? i_level : 8'h00;
        end
    end

    off_blank_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_mode == MODE_OFF) |=> (o_level == 8'h00))
        else $error("off channel drives current");
    on_pass_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_mode == MODE_ON) |=> (o_level == $past(i_level)))
        else $error("on channel does not pass level");
    gate_low_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_mode == MODE_PWM && !i_pwm_s) || (i_mode == MODE_PAT && !i_pat_s)
        |=> (o_level == 8'h00))
        else $error("gated channel drives while gate low");
endmodule : lcmlr_gate

// ===== logic/lcmlr_regs.sv
`timescale 1ns/10ps
// Function
// - channel 4 mode is bits 7:6 of register 0x01: off, on, pwm, pattern.
// - channel 3 mode is bits 5:4 with the same encoding and resets to off.
// - channel 2 mode is bits 3:2 with the same encoding and resets to off.
// - channel 1 mode is bits 1:0 and resets to pattern control.
// - channel 1 level at 0x02 is read/write, resets to 0x40, 0.1 mA a step.
// - channel 2 level at 0x03 is read/write, resets to zero, 25.5 mA at all ones.
// - channel 3 level at 0x04 resets to zero and code zero drives no current.
// - channel 4 level at 0x05 resets to zero and code 2 means 0.2 mA.
// - every level code is linear so all ones asks for the full 25.5 mA.
// - each level bit carries a binary weight, bit 7 at 12.8 mA down to 0.1 mA.
module lcmlr_regs
    import lcmlr_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [lcmlr_pkg::ADDR_W-1:0] i_addr,
    input wire logic [lcmlr_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_pwm_gate,
    input wire logic i_pattern_gate,
    output logic [lcmlr_pkg::DATA_W-1:0] o_rdata,
    output logic o_rvalid,
    output logic [1:0] o_ch1_mode_sel,
    output logic [1:0] o_ch2_mode_sel,
    output logic [1:0] o_ch3_mode_sel,
    output logic [1:0] o_ch4_mode_sel,
    output logic [7:0] o_led_output_1,
    output logic [7:0] o_led_output_2,
    output logic [7:0] o_led_output_3,
    output logic [7:0] o_led_output_4
);
    import lcmlr_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [1:0] mode_of(input logic [7:0] r, input int lsb);
        mode_of = r[lsb +: 2];
    endfunction : mode_of

    // current in microamps from binary bit weights
    function automatic int level_ua(input logic [7:0] c);
        int s;
        s = 0;
        for (int b = 0; b < 8; b++) begin
            if (c[b]) begin
                s = s + (BIT7_UA >> (7 - b));
            end
        end
        level_ua = s;
    endfunction : level_ua

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] mode_r;
    logic [7:0] lvl_r [NUM_CH];
    logic [1:0] pwm_sync_r;
    logic [1:0] pat_sync_r;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_r <= RST_MODE;
        end else if (i_wr_en && i_addr == OFS_MODE) begin
            mode_r <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lvl_r[0] <= RST_LVL1;
            lvl_r[1] <= RST_LVLX;
            lvl_r[2] <= RST_LVLX;
            lvl_r[3] <= RST_LVLX;
        end else if (i_wr_en) begin
            case (i_addr)
                OFS_LVL1: lvl_r[0] <= i_wdata;
                OFS_LVL2: lvl_r[1] <= i_wdata;
                OFS_LVL3: lvl_r[2] <= i_wdata;
                OFS_LVL4: lvl_r[3] <= i_wdata;
                default: ;
            endcase
        end
    end

    // read port answers one cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd_en;
            if (i_rd_en) begin
                case (i_addr)
                    OFS_MODE: o_rdata <= mode_r;
                    OFS_LVL1: o_rdata <= lvl_r[0];
                    OFS_LVL2: o_rdata <= lvl_r[1];
                    OFS_LVL3: o_rdata <= lvl_r[2];
                    OFS_LVL4: o_rdata <= lvl_r[3];
                    default: o_rdata <= RD_UNMAPPED;
                endcase
            end
        end
    end

    // ----------------------------------------
    // gate input synchronisers
    // ----------------------------------------
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pwm_sync_r <= 2'h0;
            pat_sync_r <= 2'h0;
        end else begin
            pwm_sync_r <= {pwm_sync_r[0], i_pwm_gate};
            pat_sync_r <= {pat_sync_r[0], i_pattern_gate};
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ch1_mode_sel <= 2'h0;
            o_ch2_mode_sel <= 2'h0;
            o_ch3_mode_sel <= 2'h0;
            o_ch4_mode_sel <= 2'h0;
        end else begin
            o_ch1_mode_sel <= mode_of(mode_r, CH1_MODE_LSB);
            o_ch2_mode_sel <= mode_of(mode_r, CH2_MODE_LSB);
            o_ch3_mode_sel <= mode_of(mode_r, CH3_MODE_LSB);
            o_ch4_mode_sel <= mode_of(mode_r, CH4_MODE_LSB);
        end
    end

    // ----------------------------------------
    // channel gates: code passes unchanged, linear 0.1 mA per step
    // ----------------------------------------
    logic [7:0] gated [NUM_CH];
    logic [1:0] ch_mode [NUM_CH];

    assign ch_mode[0] = mode_of(mode_r, CH1_MODE_LSB);
    assign ch_mode[1] = mode_of(mode_r, CH2_MODE_LSB);
    assign ch_mode[2] = mode_of(mode_r, CH3_MODE_LSB);
    assign ch_mode[3] = mode_of(mode_r, CH4_MODE_LSB);

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        lcmlr_gate u_gate (
            .i_core_clk(i_core_clk),
            .i_reset_n(i_reset_n),
            .i_mode(ch_mode[g]),
            .i_level(lvl_r[g]),
            .i_pwm_s(pwm_sync_r[1]),
            .i_pat_s(pat_sync_r[1]),
            .o_level(gated[g])
        );
    end

    assign o_led_output_1 = gated[0];
    assign o_led_output_2 = gated[1];
    assign o_led_output_3 = gated[2];
    assign o_led_output_4 = gated[3];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    rst_mode_a: assert property (@(posedge i_core_clk)
        $rose(i_reset_n) |-> (mode_r == 8'h03))
        else $error("mode register reset value wrong");
    rst_lvl_a: assert property (@(posedge i_core_clk)
        $rose(i_reset_n) |-> (lvl_r[0] == 8'h40 && lvl_r[1] == 8'h00
        && lvl_r[2] == 8'h00 && lvl_r[3] == 8'h00))
        else $error("level register reset value wrong");
    mode_wr_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_wr_en && i_addr == 8'h01) |=> ##1 (o_ch4_mode_sel == $past(i_wdata[7:6], 2)
        && o_ch3_mode_sel == $past(i_wdata[5:4], 2)
        && o_ch2_mode_sel == $past(i_wdata[3:2], 2)
        && o_ch1_mode_sel == $past(i_wdata[1:0], 2)))
        else $error("mode field placement wrong");
    lvl_rd_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_wr_en && i_addr == 8'h05) ##1 (i_rd_en && !i_wr_en && i_addr == 8'h05)
        |=> (o_rvalid && o_rdata == $past(i_wdata, 2)))
        else $error("level readback wrong");
    zero_code_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (lvl_r[2] == 8'h00) |=> (o_led_output_3 == 8'h00))
        else $error("code zero drives current");
    scale_full_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (ch_mode[0] == MODE_ON && lvl_r[0] == 8'hFF)
        |=> (o_led_output_1 == 8'hFF && level_ua(o_led_output_1) == FULL_SCALE_UA))
        else $error("full scale code not passed");
    scale_step_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (ch_mode[1] == MODE_ON)
        |=> (level_ua(o_led_output_2) == int'($past(lvl_r[1])) * STEP_UA
        && level_ua(8'h80) == BIT7_UA))
        else $error("level code not passed with binary weights");
    unmap_rd_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (i_rd_en && (i_addr == 8'h00 || i_addr > 8'h05)) |=> (o_rdata == 8'h00))
        else $error("unmapped read not zero");
endmodule : lcmlr_regs

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import lcmlr_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_wr_en = 1'b0;
    logic i_rd_en = 1'b0;
    logic i_pwm_gate = 1'b0;
    logic i_pattern_gate = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] o_rdata;
    logic o_rvalid;
    logic [1:0] o_ch1_mode_sel, o_ch2_mode_sel, o_ch3_mode_sel, o_ch4_mode_sel;
    logic [7:0] o_led_output_1, o_led_output_2, o_led_output_3, o_led_output_4;
    logic [7:0] shadow [1:5];
    logic [7:0] corner [4] = '{8'h00, 8'hFF, 8'h02, 8'h80};
    logic [7:0] old;
    integer seed = 32'hf39037c6;
    int n_checks = 0;
    int n_mismatch = 0;
    int cyc = 0;
    wire [7:0] mode_all = {o_ch4_mode_sel, o_ch3_mode_sel, o_ch2_mode_sel, o_ch1_mode_sel};
    wire [31:0] lvl_all = {o_led_output_4, o_led_output_3, o_led_output_2, o_led_output_1};

    lcmlr_regs u_dut (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_pwm_gate(i_pwm_gate), .i_pattern_gate(i_pattern_gate),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .o_ch1_mode_sel(o_ch1_mode_sel), .o_ch2_mode_sel(o_ch2_mode_sel),
        .o_ch3_mode_sel(o_ch3_mode_sel), .o_ch4_mode_sel(o_ch4_mode_sel),
        .o_led_output_1(o_led_output_1), .o_led_output_2(o_led_output_2),
        .o_led_output_3(o_led_output_3), .o_led_output_4(o_led_output_4)
    );

    // ----------------------------------------
    // clock, timeout, helpers
    // ----------------------------------------
    always #4 i_core_clk = ~i_core_clk;

    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [7:0] exp_lvl(logic [1:0] m, logic [7:0] v, logic pw, logic pt);
        case (m)
            MODE_OFF: return 8'h00;
            MODE_ON: return v;
            MODE_PWM: return pw ? v : 8'h00;
            default: return pt ? v : 8'h00;
        endcase
    endfunction : exp_lvl

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge i_core_clk);
        i_wr_en = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_core_clk);
        i_wr_en = 1'b0;
        if (a >= OFS_MODE && a <= OFS_LVL4) shadow[a] = d;
    endtask : wr

    task automatic rd_wait(logic [7:0] e);
        int k;
        k = 0;
        while (o_rvalid !== 1'b1 && k < 2) begin
            @(negedge i_core_clk);
            k++;
        end
        chk("rvalid", {7'h00, o_rvalid}, 8'h01);
        chk("rdata", o_rdata, e);
    endtask : rd_wait

    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(negedge i_core_clk);
        i_rd_en = 1'b1;
        i_addr = a;
        @(negedge i_core_clk);
        i_rd_en = 1'b0;
        rd_wait(e);
    endtask : rd

    task automatic rd_all();
        for (int a = 1; a <= 5; a++) rd(8'(a), shadow[a]);
    endtask : rd_all

    task automatic chk_outs();
        logic [1:0] m;
        repeat (5) @(negedge i_core_clk);
        for (int c = 0; c < NUM_CH; c++) begin
            m = shadow[1][2*c +: 2];
            chk("mode_sel", {6'h00, mode_all[2*c +: 2]}, {6'h00, m});
            chk("led_output", lvl_all[8*c +: 8],
                exp_lvl(m, shadow[c+2], i_pwm_gate, i_pattern_gate));
        end
    endtask : chk_outs

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        shadow = '{RST_MODE, RST_LVL1, RST_LVLX, RST_LVLX, RST_LVLX};
        repeat (2) @(negedge i_core_clk);
        i_reset_n = 1'b1;
        chk_outs();
        rd_all();
        // unmapped places are ignored on write and read as zero
        wr(8'h00, 8'hFF);
        wr(8'h06, 8'hAA);
        rd(8'h00, RD_UNMAPPED);
        rd(8'h06, RD_UNMAPPED);
        rd_all();
        // write and read in one cycle returns the old value
        old = shadow[2];
        @(negedge i_core_clk);
        i_wr_en = 1'b1;
        i_rd_en = 1'b1;
        i_addr = OFS_LVL1;
        i_wdata = ~old;
        @(negedge i_core_clk);
        i_wr_en = 1'b0;
        i_rd_en = 1'b0;
        shadow[2] = ~old;
        rd_wait(old);
        // read right behind a write returns the new value
        @(negedge i_core_clk);
        i_wr_en = 1'b1;
        i_addr = OFS_LVL4;
        i_wdata = 8'($random(seed));
        shadow[5] = i_wdata;
        @(negedge i_core_clk);
        i_wr_en = 1'b0;
        i_rd_en = 1'b1;
        @(negedge i_core_clk);
        i_rd_en = 1'b0;
        rd_wait(shadow[5]);
        for (int i = 0; i < 40; i++) begin
            wr(OFS_MODE, (i < 4) ? {4{2'(i)}} : 8'($random(seed)));
            for (int c = 0; c < NUM_CH; c++)
                wr(8'(c + 2), (i < 4) ? corner[(i + c) % 4] : 8'($random(seed)));
            i_pwm_gate = 1'($random(seed));
            i_pattern_gate = 1'($random(seed));
            chk_outs();
            // gates move with no register change
            @(negedge i_core_clk);
            i_pwm_gate = ~i_pwm_gate;
            i_pattern_gate = 1'($random(seed));
            chk_outs();
            rd_all();
        end
        // reset in mid-run brings back the reset values
        @(negedge i_core_clk);
        i_reset_n = 1'b0;
        repeat (2) @(negedge i_core_clk);
        i_reset_n = 1'b1;
        shadow = '{RST_MODE, RST_LVL1, RST_LVLX, RST_LVLX, RST_LVLX};
        chk_outs();
        rd_all();
        test_done();
    end
endmodule : tb_top
